// ===== logic/instrument_state_command_handler.sv
// Functional notes
// - mode query replies exactly one word: charge, discharge or test.
// - drain command from charging or testing moves to discharging.
// - energize command from discharging moves to charging.
// - energize command while charging advances to testing.
// - zero-clear command starts the zero-clearing procedure.
// - zero clearing announces start, then sends pass when done.
// - handler rejects every command while zero clearing runs.
// - fetch-result query is honoured only in testing mode.
`timescale 1ns/100ps
module instrument_state_command_handler (
    input wire logic core_clk, // 40 MHz system clock
    input wire logic srst, // synchronous reset, active high
    input wire state_cmd_pkg::cmd_t cmd_in, // decoded command, valid for one cycle
    input wire logic zero_done, // measurement side finished zero clearing
    output state_cmd_pkg::reply_t reply_out, // reply token, valid for one cycle
    output state_cmd_pkg::mode_t mode_out, // present working mode
    output logic zero_start, // one-cycle start pulse to measurement side
    output logic zero_busy, // zero clearing in progress
    output logic fetch_grant, // one-cycle pulse: fetch query accepted
    output logic cmd_reject, // one-cycle pulse: command refused
    output logic order_error // one-cycle pulse: mode switch not last in string
);
    import state_cmd_pkg::*;

    // command decode, shared by the state groups below
    logic take;
    logic accept;
    logic is_query;
    logic is_drain;
    logic is_energize;
    logic is_zero_clear;
    logic is_fetch;
    logic is_none;
    logic is_switch;
    logic in_testing;

    // zero-clearing group
    zc_state_t zc_q, zc_d;
    logic busy_q, busy_d;
    logic start_q, start_d;
    logic zc_finish;

    // working-mode group
    mode_t mode_q, mode_d;

    // reply group
    reply_t reply_q, reply_d;

    // status-pulse group
    logic fetch_q, fetch_d;
    logic rej_q, rej_d;
    logic ord_q, ord_d;

    // cmd_in comes from the parser on this clock, so no synchroniser
    always_comb begin
        take = cmd_in.valid;
        accept = take && (zc_q == ZC_IDLE);
        is_query = (cmd_in.code == CMD_QUERY_MODE);
        is_drain = (cmd_in.code == CMD_DRAIN);
        is_energize = (cmd_in.code == CMD_ENERGIZE);
        is_zero_clear = (cmd_in.code == CMD_ZERO_CLEAR);
        is_fetch = (cmd_in.code == CMD_FETCH);
        is_none = (cmd_in.code == CMD_NONE);
        is_switch = is_drain || is_energize;
        in_testing = (mode_q == MODE_TESTING);
    end

    // busy is its own flop so the pin never shows a decode glitch
    always_comb begin
        zc_d = zc_q;
        start_d = 1'b0;
        zc_finish = 1'b0;
        case (zc_q)
            ZC_IDLE: begin
                // zero_done while idle is a stray pulse and is ignored
                if (accept && is_zero_clear) begin
                    zc_d = ZC_BUSY;
                    start_d = 1'b1;
                end
            end
            ZC_BUSY: begin
                // a command in the finishing cycle is still refused
                if (zero_done) begin
                    zc_d = ZC_IDLE;
                    zc_finish = 1'b1;
                end
            end
            default: begin
                // illegal code: fall back to idle rather than lock the parser
                zc_d = ZC_IDLE;
            end
        endcase
        busy_d = (zc_d == ZC_BUSY);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            zc_q <= ZC_IDLE;
            busy_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            zc_q <= zc_d;
            busy_q <= busy_d;
            start_q <= start_d;
        end
    end

    // commands in the lock window never reach here: accept is low while busy
    always_comb begin
        mode_d = mode_q;
        if (accept && is_drain) begin
            // already discharging: silent no-op
            if (mode_q != MODE_DISCHARGING) begin
                mode_d = MODE_DISCHARGING;
            end
        end else if (accept && is_energize) begin
            case (mode_q)
                MODE_DISCHARGING: begin
                    mode_d = MODE_CHARGING;
                end
                MODE_CHARGING: begin
                    mode_d = MODE_TESTING;
                end
                MODE_TESTING: begin
                    // no further step past testing
                    mode_d = MODE_TESTING;
                end
                default: begin
                    mode_d = mode_q;
                end
            endcase
        end
    end

    // mode comes up discharging, the safe state for the output stage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // idle code is a don't-care; receivers look at valid only
    always_comb begin
        reply_d = '{valid: 1'b0, code: RPL_PASS};
        if (zc_finish) begin
            reply_d = '{valid: 1'b1, code: RPL_PASS};
        end
        if (accept && is_query) begin
            reply_d.valid = 1'b1;
            case (mode_q)
                MODE_CHARGING: begin
                    reply_d.code = RPL_CHARGE;
                end
                MODE_TESTING: begin
                    reply_d.code = RPL_TEST;
                end
                default: begin
                    reply_d.code = RPL_DISCHARGE;
                end
            endcase
        end
        if (accept && is_zero_clear) begin
            reply_d = '{valid: 1'b1, code: RPL_CLEAR_START};
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reply_q <= '{valid: 1'b0, code: RPL_PASS};
        end else begin
            reply_q <= reply_d;
        end
    end

    always_comb begin
        fetch_d = 1'b0;
        rej_d = 1'b0;
        ord_d = 1'b0;
        if (take && !accept) begin
            rej_d = 1'b1;
        end
        if (accept) begin
            // a switch that is not last is still obeyed, only flagged
            ord_d = is_switch && !cmd_in.last;
            if (is_fetch) begin
                // fetch outside testing is refused, not queued
                fetch_d = in_testing;
                rej_d = !in_testing;
            end
            if (is_none) begin
                // valid with no command code is a parser fault
                rej_d = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fetch_q <= 1'b0;
            rej_q <= 1'b0;
            ord_q <= 1'b0;
        end else begin
            fetch_q <= fetch_d;
            rej_q <= rej_d;
            ord_q <= ord_d;
        end
    end

    // every output is a register, no decode on the pins
    assign reply_out = reply_q;
    assign mode_out = mode_q;
    assign zero_start = start_q;
    assign zero_busy = busy_q;
    assign fetch_grant = fetch_q;
    assign cmd_reject = rej_q;
    assign order_error = ord_q;

endmodule // instrument_state_command_handler

// ===== logic/state_cmd_pkg.sv
package state_cmd_pkg;

    // decoded commands from the text parser
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_QUERY_MODE = 3'h1,
        CMD_DRAIN = 3'h2,
        CMD_ENERGIZE = 3'h3,
        CMD_ZERO_CLEAR = 3'h4,
        CMD_FETCH = 3'h5,
        CMD_OTHER = 3'h6
    } cmd_code_t;

    typedef struct packed {
        logic valid;
        logic last;
        cmd_code_t code;
    } cmd_t;

    typedef enum logic [2:0] {
        RPL_CHARGE = 3'h0,
        RPL_DISCHARGE = 3'h1,
        RPL_TEST = 3'h2,
        RPL_CLEAR_START = 3'h3,
        RPL_PASS = 3'h4
    } reply_code_t;

    typedef struct packed {
        logic valid;
        reply_code_t code;
    } reply_t;

    typedef enum logic [2:0] {
        MODE_CHARGING = 3'b001,
        MODE_DISCHARGING = 3'b010,
        MODE_TESTING = 3'b100
    } mode_t;

    typedef enum logic [1:0] {
        ZC_IDLE = 2'b01,
        ZC_BUSY = 2'b10
    } zc_state_t;

    localparam mode_t MODE_RESET = MODE_DISCHARGING;

endpackage

// ===== test/hsm_asserts.sv
`timescale 1ns/100ps
module hsm_asserts import state_cmd_pkg::*; (
    input wire logic core_clk,
    input wire logic srst,
    input wire cmd_t cmd_in,
    input wire logic zero_done,
    input wire reply_t reply_out,
    input wire mode_t mode_out,
    input wire logic zero_start,
    input wire logic zero_busy,
    input wire logic fetch_grant,
    input wire logic cmd_reject
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire v = cmd_in.valid && !zero_busy;
    wire [2:0] c = cmd_in.code;
    wire [2:0] w = mode_out == MODE_CHARGING ? RPL_CHARGE :
        (mode_out == MODE_TESTING ? RPL_TEST : RPL_DISCHARGE);
    sequence zc_go;
        v && c == CMD_ZERO_CLEAR;
    endsequence
    sequence zc_ack;
        zero_start && zero_busy && reply_out.valid && reply_out.code == RPL_CLEAR_START;
    endsequence
    AST_QUERY: assert property (v && c == CMD_QUERY_MODE |=> reply_out.valid && reply_out.code == $past(w)) else $error("bad mode word");
    AST_DRAIN: assert property (v && c == CMD_DRAIN && mode_out != MODE_DISCHARGING |=> mode_out == MODE_DISCHARGING) else $error("drain ignored");
    AST_ENERGIZE: assert property (v && c == CMD_ENERGIZE && mode_out == MODE_DISCHARGING |=> mode_out == MODE_CHARGING) else $error("energize ignored");
    AST_ADVANCE: assert property (v && c == CMD_ENERGIZE && mode_out == MODE_CHARGING |=> mode_out == MODE_TESTING) else $error("no advance");
    AST_ZC_START: assert property (zc_go |=> zc_ack) else $error("clear not started");
    AST_ZC_PASS: assert property (zero_busy && zero_done |=> !zero_busy && reply_out.valid && reply_out.code == RPL_PASS) else $error("no pass");
    AST_LOCK: assert property (cmd_in.valid && zero_busy |=> cmd_reject && $stable(mode_out)) else $error("busy not locked");
    AST_NOP: assert property (v && c == CMD_DRAIN && mode_out == MODE_DISCHARGING |=> !reply_out.valid && mode_out == MODE_DISCHARGING) else $error("drain not idle");
    AST_FETCH: assert property (v && c == CMD_FETCH |=> fetch_grant == ($past(mode_out) == MODE_TESTING)) else $error("bad fetch");
endmodule // hsm_asserts
bind instrument_state_command_handler hsm_asserts chk_u (.*);

// ===== test/meas_model.sv
`timescale 1ns/100ps
module meas_model #(parameter int DLY = 6) (
    input wire logic core_clk, // system clock
    input wire logic zero_start, // start pulse
    output logic zero_done // done pulse
);
    int n = 0;
    initial zero_done = 1'b0;
    // drives on the falling edge, away from the design's sampling edge
    always @(negedge core_clk) begin
        zero_done <= n == 1;
        n <= zero_start ? DLY : (n > 0 ? n - 1 : 0);
    end
endmodule // meas_model

// ===== test/tb.sv
`timescale 1ns/100ps
module tb;
    import state_cmd_pkg::*;
    logic core_clk = 0, srst = 1, zero_done, zero_start, zero_busy, fetch_grant, cmd_reject;
    logic order_error;
    cmd_t cmd_in = '0;
    reply_t reply_out;
    mode_t mode_out, em;
    cmd_code_t c;
    cmd_code_t tbl[6] = '{CMD_ENERGIZE, CMD_ENERGIZE, CMD_ENERGIZE, CMD_FETCH, CMD_DRAIN,
        CMD_QUERY_MODE};
    int err_count = 0, n_checks = 0, i;
    logic l;
    initial forever #12.5 core_clk = ~core_clk;
    instrument_state_command_handler dut_u (.*);
    meas_model mm_u (.core_clk(core_clk), .zero_start(zero_start), .zero_done(zero_done));
    function automatic reply_t exp_r(cmd_code_t k, mode_t m);
        exp_r = '0;
        if (k == CMD_QUERY_MODE) exp_r = {1'b1, m == MODE_CHARGING ? RPL_CHARGE :
            (m == MODE_TESTING ? RPL_TEST : RPL_DISCHARGE)};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic send(cmd_code_t k, logic last);
        @(negedge core_clk) cmd_in = {1'b1, last, k};
        @(negedge core_clk) cmd_in = '0;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h116f));
        repeat (3) @(negedge core_clk);
        srst = 0;
        em = MODE_DISCHARGING;
        for (i = 0; i < 40; i++) begin
            c = i < 6 ? tbl[i] : tbl[$urandom % 6];
            l = 1'($urandom % 2);
            send(c, l);
            chk(reply_out.valid ? reply_out : '0, exp_r(c, em));
            chk(fetch_grant, c == CMD_FETCH && em == MODE_TESTING);
            chk(cmd_reject, c == CMD_FETCH && em != MODE_TESTING);
            chk(order_error, (c == CMD_DRAIN || c == CMD_ENERGIZE) && !l);
            if (c == CMD_DRAIN) em = MODE_DISCHARGING;
            if (c == CMD_ENERGIZE && em != MODE_TESTING)
                em = em == MODE_DISCHARGING ? MODE_CHARGING : MODE_TESTING;
            chk(mode_out, em);
        end
        send(CMD_ZERO_CLEAR, 1'b1);
        chk({reply_out, zero_busy, zero_start}, {1'b1, RPL_CLEAR_START, 2'b11});
        send(CMD_DRAIN, 1'b1);
        chk({cmd_reject, mode_out}, {1'b1, em});
        for (i = 0; i < 50 && reply_out.valid !== 1'b1; i++) @(negedge core_clk);
        if (i == 50) err_count++;
        chk({reply_out, zero_busy}, {1'b1, RPL_PASS, 1'b0});
        final_report();
    end
endmodule // tb
